//--- rtl/ldi_pkg.sv
package ldi_pkg;
  // ---------------------------------------------------------------
  // addresses and reset values (8-bit form, direction bit 0)
  // ---------------------------------------------------------------
  localparam logic [7:0] BCAST_ADDR_RST = 8'hd0;
  localparam logic [7:0] GRP1_ADDR_RST = 8'hd2;
  localparam logic [7:0] GRP2_ADDR_RST = 8'hd4;
  localparam logic [7:0] GRP3_ADDR_RST = 8'hd8;
  localparam logic [7:0] SOFT_RESET_ADDR = 8'hd6;
  localparam logic [7:0] MODE_ONE_RST = 8'h01;
  // ---------------------------------------------------------------
  // mode register one bit positions
  // ---------------------------------------------------------------
  localparam int BCAST_EN_BIT = 0;
  localparam int GRP3_EN_BIT = 1;
  localparam int GRP2_EN_BIT = 2;
  localparam int GRP1_EN_BIT = 3;
  // ---------------------------------------------------------------
  // pointer ranges
  // ---------------------------------------------------------------
  localparam logic [4:0] PTR_LAST_ALL = 5'h1b;
  localparam logic [4:0] PTR_FIRST_LED = 5'h02;
  localparam logic [4:0] PTR_LAST_LED = 5'h11;
  localparam logic [4:0] PTR_FIRST_GRP = 5'h12;
  localparam logic [4:0] PTR_LAST_GRP = 5'h13;
  localparam logic [2:0] AI_NONE = 3'h0;
  localparam logic [2:0] AI_ALL = 3'h4;
  localparam logic [2:0] AI_LED = 3'h5;
  localparam logic [2:0] AI_GRP = 3'h6;
  localparam logic [2:0] AI_LED_GRP = 3'h7;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMO_W = 21;
  // ---------------------------------------------------------------
  // receive state machine
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    LDI_IDLE = 5'b00001,
    LDI_ADDR = 5'b00010,
    LDI_WDAT = 5'b00100,
    LDI_RDAT = 5'b01000,
    LDI_IGN = 5'b10000
  } ldi_state_t;
endpackage

//--- rtl/ldi_filt_if.sv
`timescale 1ns/100ps
// filtered bus line levels between filter and protocol logic
interface ldi_filt_if;
  logic scl;
  logic sda;
  modport src (output scl, output sda);
  modport dst (input scl, input sda);
endinterface

//--- rtl/ldi_filter.sv
`timescale 1ns/100ps
module ldi_filter
  import ldi_pkg::*;
#(
  parameter int STABLE_CYC = SPIKE_CYC
) (
  input wire logic clk,             // system clock
  input wire logic resetn,          // synchronous reset
  input wire logic scl_in,          // raw clock line
  input wire logic sda_in,          // raw data line
  ldi_filt_if.src filt              // filtered levels
);
  logic [1:0] lvl_reg, lvl_next;
  logic [1:0] cnt_reg [2];
  logic [1:0] cnt_next [2];
  logic [1:0] raw;
  assign raw = {sda_in, scl_in};
  // ---------------------------------------------------------------
  // spike filter
  // ---------------------------------------------------------------
  // spike suppression counter
  // level only follows after STABLE_CYC+1 agreeing samples
  always_comb begin
    lvl_next = lvl_reg;
    for (int i = 0; i < 2; i++) begin
      cnt_next[i] = 2'h0;
      if (raw[i] != lvl_reg[i]) begin
        cnt_next[i] = cnt_reg[i] + 2'h1;
        if (cnt_reg[i] == 2'(STABLE_CYC)) begin
          lvl_next[i] = raw[i];
          cnt_next[i] = 2'h0;
        end
      end
    end
  end
  // registers, idle bus is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lvl_reg <= 2'h3;
      cnt_reg[0] <= 2'h0;
      cnt_reg[1] <= 2'h0;
    end else begin
      lvl_reg <= lvl_next;
      cnt_reg <= cnt_next;
    end
  end
  assign filt.scl = lvl_reg[0];
  assign filt.sda = lvl_reg[1];
  chk_spike_blocked: assert property (@(posedge clk) disable iff (!resetn)
    ($changed(lvl_reg[0]) |-> $past(raw[0]) == lvl_reg[0] &&
     $past(raw[0], 2) == lvl_reg[0] && $past(raw[0], 3) == lvl_reg[0]))
    else $error("scl level changed after too short a pulse");
endmodule

//--- rtl/ldi_target.sv
`timescale 1ns/100ps
module ldi_target
  import ldi_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h60,      // regular address
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC    // bus stuck limit
) (
  input wire logic CLK,                          // 50 MHz clock
  input wire logic RESETN,                       // sync reset, low
  input wire logic SCL_IN,                       // clock line in
  input wire logic SDA_IN,                       // data line in
  output logic SDA_OUT,                          // data out, always 0
  output logic SDA_OE,                           // high pulls data low
  input wire logic TIMEOUT_EN,                   // stuck bus time-out on
  input wire logic [7:0] MODE_ONE,               // mode register one
  input wire logic [7:0] BCAST_ADDR,             // broadcast address
  input wire logic [7:0] GRP1_ADDR,              // group address one
  input wire logic [7:0] GRP2_ADDR,              // group address two
  input wire logic [7:0] GRP3_ADDR,              // group address three
  input wire logic [7:0] RD_DATA,                // register read data
  output logic [7:0] CTRL,                       // control byte
  output logic [7:0] WR_DATA,                    // written data byte
  output logic WR_STB,                           // data byte written
  output logic RD_STB,                           // data byte sent and acked by the controller
  output logic SOFT_RESET_CALL                   // soft reset pulse
);
  import ldi_pkg::*;


  // ---------------------------------------------------------------
  // pointer arithmetic
  // ---------------------------------------------------------------
  // range ends come from the register layout
  function automatic logic [4:0] ptr_step(input logic [7:0] cb);
    logic [4:0] p;
    p = cb[4:0];
    // beyond range climbs to 00 first
    case (cb[7:5])
      AI_ALL: ptr_step = (p >= PTR_LAST_ALL) ? 5'h00 : p + 5'h01;
      AI_LED: ptr_step = (p == PTR_LAST_LED) ? PTR_FIRST_LED :
        (p >= PTR_LAST_ALL) ? 5'h00 : p + 5'h01;
      AI_GRP: ptr_step = (p == PTR_LAST_GRP) ? PTR_FIRST_GRP :
        (p >= PTR_LAST_ALL) ? 5'h00 : p + 5'h01;
      AI_LED_GRP: ptr_step = (p == PTR_LAST_GRP) ? PTR_FIRST_LED :
        (p >= PTR_LAST_ALL) ? 5'h00 : p + 5'h01;
      default: ptr_step = p;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // filtered lines and bus conditions
  // ---------------------------------------------------------------
  ldi_filt_if filt ();
  ldi_filter #(.STABLE_CYC(SPIKE_CYC)) u_filt (
    .clk(CLK),
    .resetn(RESETN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .filt(filt)
  );

  logic scl_d_reg, sda_d_reg;
  logic start_c, stop_c, rise_c, fall_c;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= filt.scl;
      sda_d_reg <= filt.sda;
    end
  end
  // edges of the already filtered lines
  assign start_c = filt.scl && scl_d_reg && sda_d_reg && !filt.sda;
  assign stop_c = filt.scl && scl_d_reg && !sda_d_reg && filt.sda;
  assign rise_c = filt.scl && !scl_d_reg;
  assign fall_c = !filt.scl && scl_d_reg;

  // ---------------------------------------------------------------
  // stuck bus time-out
  // ---------------------------------------------------------------
  logic [TMO_W-1:0] tmo_reg, tmo_next;
  logic tmo_hit;
  // count while either line is low
  always_comb begin
    tmo_next = '0;
    if (TIMEOUT_EN && (!filt.scl || !filt.sda) &&
        tmo_reg != TMO_W'(TIMEOUT_CYCLES))
      tmo_next = tmo_reg + TMO_W'(1);
    else if (TIMEOUT_EN && (!filt.scl || !filt.sda))
      tmo_next = tmo_reg;
  end
  assign tmo_hit = tmo_reg == TMO_W'(TIMEOUT_CYCLES - 1);
  always_ff @(posedge CLK) begin
    if (!RESETN)
      tmo_reg <= '0;
    else
      tmo_reg <= tmo_next;
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  ldi_state_t st_reg, st_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic ctl_pend_reg, ctl_pend_next;
  logic sr_pend_reg, sr_pend_next;
  logic oe_reg, oe_next;
  logic ack_reg, ack_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] wd_reg, wd_next;
  logic wstb_reg, wstb_next, rstb_reg, rstb_next, srst_reg, srst_next;
  logic addr_hit;
  logic [7:0] abyte;
  assign abyte = {sh_reg[6:0], filt.sda};

  // address match of the byte held after eight clocks
  always_comb begin
    addr_hit = 1'b0;
    if (sh_reg[7:1] == DEV_ADDR)
      addr_hit = 1'b1;
    if (sh_reg[7:1] == BCAST_ADDR[7:1] && MODE_ONE[BCAST_EN_BIT])
      addr_hit = 1'b1;
    if (sh_reg[7:1] == GRP1_ADDR[7:1] && MODE_ONE[GRP1_EN_BIT])
      addr_hit = 1'b1;
    if (sh_reg[7:1] == GRP2_ADDR[7:1] && MODE_ONE[GRP2_EN_BIT])
      addr_hit = 1'b1;
    if (sh_reg[7:1] == GRP3_ADDR[7:1] && MODE_ONE[GRP3_EN_BIT])
      addr_hit = 1'b1;
    if (sh_reg == SOFT_RESET_ADDR)
      addr_hit = 1'b1;
  end

  // protocol next state; bit 8 of a byte is the acknowledge slot
  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    ctl_pend_next = ctl_pend_reg;
    sr_pend_next = sr_pend_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    ctrl_next = ctrl_reg;
    wd_next = wd_reg;
    wstb_next = 1'b0;
    rstb_next = 1'b0;
    srst_next = 1'b0;
    if (start_c) begin
      st_next = LDI_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b0;
      ack_next = 1'b0;
      sr_pend_next = 1'b0;
    end else if (stop_c) begin
      st_next = LDI_IDLE;
      oe_next = 1'b0;
      // flag kept apart: the stop clock shifts sh_reg first
      if (ack_reg && sr_pend_reg)
        srst_next = 1'b1;
      ack_next = 1'b0;
      sr_pend_next = 1'b0;
    end else begin
      case (st_reg)
        LDI_IDLE: begin
          oe_next = 1'b0;
        end
        LDI_ADDR, LDI_WDAT: begin
          if (rise_c && bit_reg < 4'h8) begin
            sh_next = abyte;
            bit_next = bit_reg + 4'h1;
          end
          if (fall_c && bit_reg == 4'h8) begin
            oe_next = 1'b1;
            if (st_reg == LDI_ADDR) begin
              if (addr_hit) begin
                ack_next = 1'b1;
                st_next = sh_reg[0] ? LDI_RDAT : LDI_WDAT;
                // new write transfer reloads control
                // soft reset call carries no control byte
                sr_pend_next = sh_reg == SOFT_RESET_ADDR;
                ctl_pend_next = !sh_reg[0] && !sr_pend_next;
              end else begin
                oe_next = 1'b0;
                st_next = LDI_IGN;
              end
            end else if (sr_pend_reg) begin
              // bytes after a soft reset call are acked, not used
              oe_next = 1'b1;
            end else if (ctl_pend_reg) begin
              // first data byte is the control byte
              // its pointer picks the first register
              ctrl_next = sh_reg;
              ctl_pend_next = 1'b0;
            end else begin
              wd_next = sh_reg;
              wstb_next = 1'b1;
              ctrl_next = {ctrl_reg[7:5], ptr_step(ctrl_reg)};
            end
          end
          if (fall_c && bit_reg == 4'h9) begin
            oe_next = 1'b0;
            bit_next = 4'h0;
          end
          if (rise_c && bit_reg == 4'h8)
            bit_next = 4'h9;
        end
        LDI_RDAT: begin
          // after address ack, drive data bits at once, then release for the controller's ack
          if (fall_c) begin
            if (bit_reg == 4'h8 && oe_reg) begin
              // fetch late so an advanced pointer is already applied
              bit_next = 4'h0;
              sh_next = RD_DATA;
              oe_next = !RD_DATA[7];
            end else if (bit_reg < 4'h7) begin
              oe_next = !sh_reg[6];
              sh_next = {sh_reg[6:0], 1'b0};
              bit_next = bit_reg + 4'h1;
            end else if (bit_reg == 4'h7) begin
              oe_next = 1'b0;
              bit_next = 4'h9;
            end
          end
          if (rise_c && bit_reg == 4'h9) begin
            if (filt.sda) begin
              st_next = LDI_IGN;
            end else begin
              rstb_next = 1'b1;
              ctrl_next = {ctrl_reg[7:5], ptr_step(ctrl_reg)};
              bit_next = 4'h8;
              oe_next = 1'b1;
            end
          end
        end
        LDI_IGN: begin
          oe_next = 1'b0;
        end
        default: begin
          st_next = LDI_IDLE;
        end
      endcase
    end
    if (tmo_hit) begin
      st_next = LDI_IDLE;
      oe_next = 1'b0;
      ack_next = 1'b0;
      ctl_pend_next = 1'b0;
      sr_pend_next = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      st_reg <= LDI_IDLE;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      ctl_pend_reg <= 1'b0;
      sr_pend_reg <= 1'b0;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      ctrl_reg <= 8'h00;
      wd_reg <= 8'h00;
      wstb_reg <= 1'b0;
      rstb_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      ctl_pend_reg <= ctl_pend_next;
      sr_pend_reg <= sr_pend_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      ctrl_reg <= ctrl_next;
      wd_reg <= wd_next;
      wstb_reg <= wstb_next;
      rstb_reg <= rstb_next;
      srst_reg <= srst_next;
    end
  end

  // outputs straight from flip-flops, SDA_OUT tied to 0; data pin only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE = oe_reg;
  assign CTRL = ctrl_reg;
  assign WR_DATA = wd_reg;
  assign WR_STB = wstb_reg;
  assign RD_STB = rstb_reg;
  assign SOFT_RESET_CALL = srst_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_wrap_all_mode: assert property (@(posedge CLK) disable iff (!RESETN)
    (wstb_next && ctrl_reg == {AI_ALL, PTR_LAST_ALL}) |=>
      ctrl_reg == {AI_ALL, 5'h00})
    else $error("option 100 did not wrap to zero");
  chk_wrap_led_mode: assert property (@(posedge CLK) disable iff (!RESETN)
    (wstb_next && ctrl_reg == {AI_LED, PTR_LAST_LED}) |=>
      ctrl_reg == {AI_LED, PTR_FIRST_LED})
    else $error("option 101 did not wrap to 02");
  chk_wrap_grp_mode: assert property (@(posedge CLK) disable iff (!RESETN)
    ((wstb_next || rstb_next) && ctrl_reg == {AI_GRP, PTR_LAST_GRP}) |=>
      ctrl_reg == {AI_GRP, PTR_FIRST_GRP})
    else $error("option 110 did not wrap to 12");
  chk_wrap_both_mode: assert property (@(posedge CLK) disable iff (!RESETN)
    (wstb_next && ctrl_reg == {AI_LED_GRP, PTR_LAST_GRP}) |=>
      ctrl_reg == {AI_LED_GRP, PTR_FIRST_LED})
    else $error("option 111 did not wrap to 02");
  chk_fixed_pointer: assert property (@(posedge CLK) disable iff (!RESETN)
    (WR_STB && CTRL[7:5] == AI_NONE) |-> $stable(CTRL))
    else $error("pointer moved with auto-increment off");
  chk_option_kept: assert property (@(posedge CLK) disable iff (!RESETN)
    (WR_STB || RD_STB) |-> CTRL[7:5] == $past(CTRL[7:5]))
    else $error("option bits changed on advance");
  chk_soft_rst_read: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_reg == LDI_ADDR && fall_c && bit_reg == 4'h8 &&
     sh_reg == (SOFT_RESET_ADDR | 8'h01) && sh_reg[7:1] != DEV_ADDR) |=>
     !SDA_OE)
    else $error("soft reset read was acknowledged");
  chk_grp_silent: assert property (@(posedge CLK) disable iff (!RESETN)
    (st_reg == LDI_ADDR && fall_c && bit_reg == 4'h8 &&
     MODE_ONE[3:0] == 4'h0 && sh_reg[7:1] != DEV_ADDR &&
     sh_reg != SOFT_RESET_ADDR) |=> !SDA_OE)
    else $error("acknowledged while all group and broadcast off");
  chk_timeout_idle: assert property (@(posedge CLK) disable iff (!RESETN)
    tmo_hit |=> st_reg == LDI_IDLE && !SDA_OE)
    else $error("time-out did not reset interface");
  cov_write_burst: cover property (@(posedge CLK) WR_STB ##[1:1000] WR_STB);
  cov_read_byte: cover property (@(posedge CLK) RD_STB);
  cov_soft_reset: cover property (@(posedge CLK) SOFT_RESET_CALL);
endmodule

//--- tb/ldi_bus_ctrl.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// bus controller model on the far side of the target
// ---------------------------------------------------------------
module ldi_bus_ctrl (
  input wire logic clk,       // system clock
  input wire logic sda_line,  // resolved data line, pulled up
  output logic scl,           // clock line, driven by us only
  output logic sda_pull       // high pulls the data line low
);
  int q = 10;                 // half bit time in cycles, raise to go slow
  logic glitch = 1'b0;        // add a short clock spike in every bit
  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // every change lands just after a rising edge
  task automatic wq(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sda_pull = 1'b0;
    wq(q);
    scl = 1'b1;
    wq(q);
    sda_pull = 1'b1;
    wq(q);
    scl = 1'b0;
    wq(4);
  endtask
  // stop: data rises while clock high
  task automatic stop();
    sda_pull = 1'b1;
    wq(q);
    scl = 1'b1;
    wq(q);
    sda_pull = 1'b0;
    wq(q);
  endtask
  // one clock pulse; data held past the fall so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    wq(q);
    if (glitch) begin
      // 40 ns spike, shorter than the filter must swallow
      scl = 1'b1;
      wq(2);
      scl = 1'b0;
      wq(q);
    end
    scl = 1'b1;
    wq(q);
    r = sda_line;
    scl = 1'b0;
    wq(4);
  endtask
  // byte out msb first, ninth clock returns the target's ack
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // byte in msb first, then our ack or nack
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(~ack, r);
  endtask
endmodule

//--- tb/tb_led_driver_i2c_addr_pointer.sv
`timescale 1ns/100ps
module tb_led_driver_i2c_addr_pointer;
  import ldi_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic timeout_en = 1'b0;
  logic [7:0] mode_one = MODE_ONE_RST;
  logic [7:0] grp1_addr = GRP1_ADDR_RST;
  logic [7:0] bcast_addr = BCAST_ADDR_RST;
  logic [7:0] grp2_addr = GRP2_ADDR_RST;
  logic [7:0] grp3_addr = GRP3_ADDR_RST;
  logic [7:0] rd_data;
  logic [7:0] ctrl, wr_data, prev_ctrl, wptr, wdat;
  logic sda_out, sda_oe, wr_stb, rd_stb, sr_call, scl, sda_pull, sda_line;
  int miscompares = 0;
  int n_compared = 0;
  int wn = 0;
  int sr_cnt = 0;
  int rn = 0;
  // open-drain data line with pull-up
  assign sda_line = ~(sda_pull | sda_oe);
  // register data model: tag bits plus the pointer it came from
  assign rd_data = {3'h5, ctrl[4:0]};
  initial begin
    forever #10 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // design, far side and register data
  // ---------------------------------------------------------------
  ldi_target #(.DEV_ADDR(7'h60), .TIMEOUT_CYCLES(300)) uut (
    .CLK(clk), .RESETN(resetn), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .TIMEOUT_EN(timeout_en),
    .MODE_ONE(mode_one), .BCAST_ADDR(bcast_addr), .GRP1_ADDR(grp1_addr),
    .GRP2_ADDR(grp2_addr), .GRP3_ADDR(grp3_addr), .RD_DATA(rd_data),
    .CTRL(ctrl), .WR_DATA(wr_data), .WR_STB(wr_stb), .RD_STB(rd_stb),
    .SOFT_RESET_CALL(sr_call));
  ldi_bus_ctrl p (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_pull(sda_pull));
  // log each written byte with the pointer it was aimed at
  always @(posedge clk) begin
    prev_ctrl <= ctrl;
    if (wr_stb === 1'b1) begin
      wn++;
      wptr = prev_ctrl;
      wdat = wr_data;
    end
    if (sr_call === 1'b1) begin
      sr_cnt++;
    end
    if (rd_stb === 1'b1) begin
      rn++;
    end
  end
  // ---------------------------------------------------------------
  // comparison, verdict and expected pointer steps
  // ---------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  function automatic logic [4:0] nxt(input logic [2:0] o, logic [4:0] a);
    if (!o[2]) return a;
    if (o == 3'h5 && a == 5'h11) return 5'h02;
    if (o[1] && a == 5'h13) return o[0] ? 5'h02 : 5'h12;
    if (a >= 5'h1b) return 5'h00;
    return a + 5'h01;
  endfunction
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // control byte then n data bytes, pointer followed byte by byte
  task automatic wr_seq(input logic [7:0] c, input int n);
    logic ack;
    logic [4:0] a;
    p.start();
    p.wr_byte(8'hc0, ack);
    check({7'h0, ack}, 8'h01);
    p.wr_byte(c, ack);
    check(ctrl, c);
    a = c[4:0];
    for (int i = 0; i < n; i++) begin
      p.wr_byte(8'h40 + 8'(i), ack);
      check({3'h0, wptr[4:0]}, {3'h0, a});
      check(wdat, 8'h40 + 8'(i));
      check({5'h0, ctrl[7:5]}, {5'h0, c[7:5]});
      a = nxt(c[7:5], a);
    end
    p.stop();
  endtask
  // every mode at its rollover edge; reserved codes 001..011 never sent
  task automatic sc_autoinc();
    logic [7:0] cs [6] = '{8'h05, 8'h9b, 8'hb1, 8'hd3, 8'hfa, 8'hf3};
    int w0;
    foreach (cs[i]) begin
      w0 = wn;
      wr_seq(cs[i], 3);
      check(8'(wn - w0), 8'h03);
    end
  endtask
  // slow reads with option 101 across its rollover
  task automatic sc_read();
    logic ack;
    logic [7:0] d;
    logic [7:0] exp [3] = '{8'hb0, 8'hb1, 8'ha2};
    int r0;
    wr_seq(8'hb0, 0);
    r0 = rn;
    p.q = 40;
    p.start();
    p.wr_byte(8'hc1, ack);
    check({7'h0, ack}, 8'h01);
    foreach (exp[i]) begin
      p.rd_byte(i < 2, d);
      check(d, exp[i]);
    end
    p.stop();
    p.q = 10;
    check({5'h0, ctrl[7:5]}, 8'h05);
    check(8'(rn - r0), 8'h02);
  endtask
  // address decode under mode enables; regular address is not D0
  task automatic sc_addr();
    logic [24:0] t [17] = '{
      {8'h01, 8'hd2, 8'hd0, 1'b1}, {8'h01, 8'hd2, 8'hd1, 1'b1},
      {8'h00, 8'hd2, 8'hd0, 1'b0}, {8'h01, 8'hd2, 8'hd2, 1'b0},
      {8'h01, 8'hd2, 8'hd3, 1'b0}, {8'h01, 8'hd2, 8'hd5, 1'b0},
      {8'h01, 8'hd2, 8'hd9, 1'b0}, {8'h0f, 8'hd2, 8'hd2, 1'b1},
      {8'h0f, 8'hd2, 8'hd4, 1'b1}, {8'h0f, 8'hd2, 8'hd9, 1'b1},
      {8'h0f, 8'ha4, 8'ha4, 1'b1}, {8'h0f, 8'ha4, 8'hd2, 1'b0},
      {8'h01, 8'hd2, 8'hd6, 1'b1}, {8'h01, 8'hd2, 8'hd7, 1'b0},
      {8'h01, 8'hd2, 8'hc0, 1'b1}, {8'h01, 8'hd2, 8'hc1, 1'b1},
      {8'h01, 8'hd2, 8'hc2, 1'b0}};
    logic ack;
    logic [7:0] d;
    int s0;
    foreach (t[i]) begin
      @(posedge clk);
      #1;
      mode_one = t[i][24:17];
      grp1_addr = t[i][16:9];
      s0 = sr_cnt;
      p.start();
      p.wr_byte(t[i][8:1], ack);
      check({7'h0, ack}, {7'h0, t[i][0]});
      if (ack && t[i][1]) begin
        p.rd_byte(1'b0, d);
      end
      p.stop();
      p.wq(8);
      check(8'(sr_cnt - s0), {7'h0, t[i][8:1] == 8'hd6});
    end
    // broadcast address moved: new value answers, old one not
    bcast_addr = 8'ha0;
    p.start();
    p.wr_byte(8'ha1, ack);
    check({7'h0, ack}, 8'h01);
    p.rd_byte(1'b0, d);
    p.stop();
    p.start();
    p.wr_byte(BCAST_ADDR_RST, ack);
    check({7'h0, ack}, 8'h00);
    p.stop();
    bcast_addr = BCAST_ADDR_RST;
  endtask
  // spikes on the clock line must not add bits
  task automatic sc_glitch();
    logic ack;
    p.glitch = 1'b1;
    p.start();
    p.wr_byte(8'hc0, ack);
    check({7'h0, ack}, 8'h01);
    p.wr_byte(8'h87, ack);
    p.glitch = 1'b0;
    p.stop();
    check(ctrl, 8'h87);
  endtask
  // clock held low during ack: released only when time-out is on
  task automatic sc_timeout(input logic en);
    logic r;
    timeout_en = en;
    p.start();
    for (int i = 7; i >= 0; i--) begin
      p.bit_io(i >= 6, r);
    end
    p.sda_pull = 1'b0;
    p.wq(10);
    check({7'h0, sda_oe}, 8'h01);
    check({7'h0, sda_out}, 8'h00);
    p.wq(250);
    check({7'h0, sda_oe}, {7'h0, ~en});
    p.bit_io(1'b1, r);
    p.stop();
  endtask
  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    p.wq(2);
    sc_addr();
    sc_autoinc();
    sc_read();
    sc_glitch();
    sc_timeout(1'b0);
    sc_timeout(1'b1);
    wr_seq(8'h82, 2);
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule
